//--- rtl/pnpc_regs.sv
// next-page transmit, partner next-page and port configuration registers
`default_nettype none
module pnpc_regs (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // strap
  input wire logic fiber_strap,
  // management register access, one access per strobe
  input wire logic mgmt_write,
  input wire logic mgmt_read,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // auto-negotiation engine side
  input wire logic page_received,
  input wire logic [15:0] partner_page,
  input wire logic page_rx_var,
  input wire logic page_sent,
  input wire logic sent_toggle,
  input wire logic link_ok,
  output logic [15:0] outgoing_page,
  output logic page_received_flag,
  // data path controls
  output logic link_pass,
  output logic transmit_enable,
  output logic scrambler_enable,
  output logic block_code_enable,
  output logic jabber_enable,
  output logic heartbeat_test_enable,
  output logic half_duplex_loopback_enable,
  output logic carrier_extend,
  output logic preamble_delivery,
  output logic serial_receive_mode,
  output logic far_end_fault_enable,
  output logic alternate_next_page,
  output logic fiber_mode
);
  logic [15:0] next_page_transmit;
  logic [15:0] partner_next_page;
  logic [15:0] port_configuration;
  logic strap_pending;
  logic next_toggle;
  logic read_page_clear;
  logic [15:0] next_rdata;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction

  // reset level of one configuration bit, for the controls that mirror it
  function automatic logic reset_bit(input int b);
    reset_bit = pnpc_pkg::port_configuration_reset[b];
  endfunction

  // reserved bits are dropped on write so they always read as zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      next_page_transmit <= pnpc_pkg::next_page_transmit_reset;
    end else if (mgmt_write &&
                 hit(mgmt_addr, pnpc_pkg::reg_next_page_transmit)) begin
      next_page_transmit <= mgmt_wdata &
                            pnpc_pkg::next_page_transmit_mask;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      partner_next_page <= pnpc_pkg::partner_next_page_reset;
    end else if (page_received) begin
      partner_next_page <= partner_page;
    end
  end

  // strap is sampled one cycle after reset release, never under reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      strap_pending <= 1'b1;
    end else begin
      strap_pending <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      port_configuration <= pnpc_pkg::port_configuration_reset;
    end else if (mgmt_write &&
                 hit(mgmt_addr, pnpc_pkg::reg_port_configuration)) begin
      port_configuration <= mgmt_wdata &
                            pnpc_pkg::port_configuration_mask;
    end else if (strap_pending) begin
      port_configuration[pnpc_pkg::pc_fiber_select] <= fiber_strap;
    end
  end

  pnpc_toggle_track pnpc_toggle_track_inst (
    .core_clk(core_clk),
    .reset(reset),
    .page_sent(page_sent),
    .sent_toggle(sent_toggle),
    .next_toggle(next_toggle)
  );

  // the page-received flag lives with the expansion status; it clears when
  // software reads the received page it announces
  assign read_page_clear = mgmt_read &&
                           hit(mgmt_addr, pnpc_pkg::reg_partner_next_page);

  pnpc_page_rx_flag pnpc_page_rx_flag_inst (
    .core_clk(core_clk),
    .reset(reset),
    .page_rx_event(page_received),
    .page_rx_var(page_rx_var),
    .read_clear(read_page_clear),
    .alternate_enable(port_configuration[pnpc_pkg::pc_alternate_next_page]),
    .transmit_disable(port_configuration[pnpc_pkg::pc_transmit_disable]),
    .flag(page_received_flag)
  );

  always_comb begin
    next_rdata = 16'h0000;
    if (hit(mgmt_addr, pnpc_pkg::reg_next_page_transmit)) begin
      next_rdata = next_page_transmit;
      next_rdata[pnpc_pkg::np_toggle] = next_toggle;
    end else if (hit(mgmt_addr, pnpc_pkg::reg_partner_next_page)) begin
      next_rdata = partner_next_page;
    end else if (hit(mgmt_addr, pnpc_pkg::reg_port_configuration)) begin
      next_rdata = port_configuration;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_read;
    end
  end

  // read data holds until the next read, so a slow poller still sees it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mgmt_rdata <= 16'h0000;
    end else if (mgmt_read) begin
      mgmt_rdata <= next_rdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      outgoing_page <= pnpc_pkg::next_page_transmit_reset;
    end else begin
      outgoing_page <= {next_page_transmit[15:12], next_toggle,
                        next_page_transmit[pnpc_pkg::np_code_msb:0]};
    end
  end

  // data path controls, one register each; reset levels come from the
  // configuration reset word so the two can never disagree
  // link test disable forces pass whatever the link monitor reports
  always_ff @(posedge core_clk) begin
    if (reset) begin
      link_pass <= reset_bit(pnpc_pkg::pc_link_test_disable);
    end else begin
      link_pass <= link_ok |
        port_configuration[pnpc_pkg::pc_link_test_disable];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      transmit_enable <= ~reset_bit(pnpc_pkg::pc_transmit_disable);
    end else begin
      transmit_enable <=
        ~port_configuration[pnpc_pkg::pc_transmit_disable];
    end
  end

  // 100BASE-TX coding path; the bypasses only matter at 100 Mbps
  always_ff @(posedge core_clk) begin
    if (reset) begin
      scrambler_enable <= ~reset_bit(pnpc_pkg::pc_scrambler_bypass);
    end else begin
      scrambler_enable <=
        ~port_configuration[pnpc_pkg::pc_scrambler_bypass];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      block_code_enable <= ~reset_bit(pnpc_pkg::pc_block_code_bypass);
    end else begin
      block_code_enable <=
        ~port_configuration[pnpc_pkg::pc_block_code_bypass];
    end
  end

  // 10BASE-T controls; the 100 Mbps path ignores them
  always_ff @(posedge core_clk) begin
    if (reset) begin
      jabber_enable <= ~reset_bit(pnpc_pkg::pc_jabber_disable);
    end else begin
      jabber_enable <=
        ~port_configuration[pnpc_pkg::pc_jabber_disable];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      heartbeat_test_enable <= reset_bit(pnpc_pkg::pc_heartbeat_test_enable);
    end else begin
      heartbeat_test_enable <=
        port_configuration[pnpc_pkg::pc_heartbeat_test_enable];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      half_duplex_loopback_enable <=
        ~reset_bit(pnpc_pkg::pc_half_duplex_loopback_disable);
    end else begin
      half_duplex_loopback_enable <=
        ~port_configuration[pnpc_pkg::pc_half_duplex_loopback_disable];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      carrier_extend <= reset_bit(pnpc_pkg::pc_carrier_extend);
    end else begin
      carrier_extend <=
        port_configuration[pnpc_pkg::pc_carrier_extend];
    end
  end

  // receive interface formatting towards the MAC
  always_ff @(posedge core_clk) begin
    if (reset) begin
      preamble_delivery <= reset_bit(pnpc_pkg::pc_preamble_enable);
    end else begin
      preamble_delivery <=
        port_configuration[pnpc_pkg::pc_preamble_enable];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      serial_receive_mode <= reset_bit(pnpc_pkg::pc_serial_receive_mode);
    end else begin
      serial_receive_mode <=
        port_configuration[pnpc_pkg::pc_serial_receive_mode];
    end
  end

  // link level features
  always_ff @(posedge core_clk) begin
    if (reset) begin
      far_end_fault_enable <= reset_bit(pnpc_pkg::pc_far_end_fault_enable);
    end else begin
      far_end_fault_enable <=
        port_configuration[pnpc_pkg::pc_far_end_fault_enable];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      alternate_next_page <= reset_bit(pnpc_pkg::pc_alternate_next_page);
    end else begin
      alternate_next_page <=
        port_configuration[pnpc_pkg::pc_alternate_next_page];
    end
  end

  // media follows the register one edge late, so the strap value shows
  // up two edges after reset release
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fiber_mode <= reset_bit(pnpc_pkg::pc_fiber_select);
    end else begin
      fiber_mode <= port_configuration[pnpc_pkg::pc_fiber_select];
    end
  end
endmodule
`default_nettype wire

//--- rtl/pnpc_pkg.sv
// register map, field positions and reset values for the next-page/config bank
`default_nettype none
package pnpc_pkg;
  localparam logic [4:0] reg_next_page_transmit = 5'h07;
  localparam logic [4:0] reg_partner_next_page = 5'h08;
  localparam logic [4:0] reg_port_configuration = 5'h10;
  // next-page word fields (transmit and received share the layout)
  localparam int np_more_pages = 15;
  localparam int np_ack = 14;
  localparam int np_message_page = 13;
  localparam int np_second_ack = 12;
  localparam int np_toggle = 11;
  localparam int np_code_msb = 10;
  // port configuration fields
  localparam int pc_link_test_disable = 14;
  localparam int pc_transmit_disable = 13;
  localparam int pc_scrambler_bypass = 12;
  localparam int pc_block_code_bypass = 11;
  localparam int pc_jabber_disable = 10;
  localparam int pc_heartbeat_test_enable = 9;
  localparam int pc_half_duplex_loopback_disable = 8;
  localparam int pc_carrier_extend = 7;
  localparam int pc_preamble_enable = 5;
  localparam int pc_serial_receive_mode = 3;
  localparam int pc_far_end_fault_enable = 2;
  localparam int pc_alternate_next_page = 1;
  localparam int pc_fiber_select = 0;
  // reset values; bit 0 of the configuration comes from the strap pin
  localparam logic [15:0] next_page_transmit_reset = 16'h2001;
  localparam logic [15:0] partner_next_page_reset = 16'h0000;
  localparam logic [15:0] port_configuration_reset = 16'h0084;
  // writable masks: reserved bits read back as zero
  localparam logic [15:0] next_page_transmit_mask = 16'hbfff;
  localparam logic [15:0] port_configuration_mask = 16'h7faf;
endpackage
`default_nettype wire

//--- rtl/pnpc_page_rx_flag.sv
// latch-high page-received flag with clear-on-read and alternate clears
`default_nettype none
module pnpc_page_rx_flag (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // events
  input wire logic page_rx_event,
  input wire logic page_rx_var,
  input wire logic read_clear,
  input wire logic alternate_enable,
  input wire logic transmit_disable,
  // state
  output logic flag
);
  logic alt_clear;
  assign alt_clear = alternate_enable & (~page_rx_var | transmit_disable);

  // a page arriving in the clearing cycle wins, so no page is lost
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (page_rx_event) begin
      flag <= 1'b1;
    end else if (read_clear || alt_clear) begin
      flag <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- rtl/pnpc_toggle_track.sv
// tracks the toggle value for the next outgoing page
`default_nettype none
module pnpc_toggle_track (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // page sent on the line, with its toggle bit
  input wire logic page_sent,
  input wire logic sent_toggle,
  // value the next page carries
  output logic next_toggle
);
  // next page carries the inverse of what was last transmitted
  always_ff @(posedge core_clk) begin
    if (reset) begin
      next_toggle <= 1'b0;
    end else if (page_sent) begin
      next_toggle <= ~sent_toggle;
    end
  end
endmodule
`default_nettype wire

//--- testbench/pnpc_regs_sva.sv
// port assertions for the next-page and configuration bank
`default_nettype none
module pnpc_regs_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register access
  input wire logic mgmt_write,
  input wire logic mgmt_read,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  // engine side
  input wire logic page_received,
  input wire logic page_sent,
  input wire logic sent_toggle,
  input wire logic link_ok,
  input wire logic [15:0] outgoing_page,
  input wire logic page_received_flag,
  // controls
  input wire logic link_pass,
  input wire logic transmit_enable,
  input wire logic carrier_extend,
  input wire logic fiber_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic rd8;
  logic cfg_wr;
  assign rd8 = mgmt_read && mgmt_addr == 5'h08;
  assign cfg_wr = mgmt_write && mgmt_addr == 5'h10;
  a_read_answered: assert property (mgmt_read |=> mgmt_rvalid)
    else $error("read not answered");
  a_no_stray_valid: assert property (!mgmt_read |=> !mgmt_rvalid)
    else $error("answer without read");
  a_rdata_holds: assert property (!mgmt_read |=> $stable(mgmt_rdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (mgmt_read && !(mgmt_addr inside
    {5'h07, 5'h08, 5'h10}) |=> mgmt_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_flag_sets: assert property (page_received |=> page_received_flag)
    else $error("page flag not set");
  a_flag_read_clear: assert property (rd8 && !page_received
    |=> !page_received_flag) else $error("page flag not cleared");
  a_toggle_flips: assert property (page_sent ##1 !page_sent
    |=> outgoing_page[11] == !$past(sent_toggle, 2))
    else $error("toggle not inverted");
  a_link_forced: assert property (!$past(reset) && $past(link_ok)
    |-> link_pass) else $error("link pass missing");
  a_cfg_controls: assert property (cfg_wr |=> ##1
    transmit_enable == !$past(mgmt_wdata[13], 2) &&
    carrier_extend == $past(mgmt_wdata[7], 2))
    else $error("controls not from write");
  a_media_write: assert property (cfg_wr |=> ##1
    fiber_mode == $past(mgmt_wdata[0], 2)) else $error("media wrong");
  c_page: cover property (page_received);
  c_read8: cover property (rd8 ##1 mgmt_rvalid);
  c_sent: cover property (page_sent);
endmodule
bind pnpc_regs pnpc_regs_sva pnpc_regs_sva_inst (.core_clk, .reset,
  .mgmt_write, .mgmt_read, .mgmt_addr, .mgmt_wdata, .mgmt_rdata,
  .mgmt_rvalid, .page_received, .page_sent, .sent_toggle, .link_ok,
  .outgoing_page, .page_received_flag, .link_pass, .transmit_enable,
  .carrier_extend, .fiber_mode);
`default_nettype wire

//--- testbench/pnpc_an_partner.sv
// negotiation engine stand-in driving the bank's engine side
`default_nettype none
module pnpc_an_partner (
  // clock
  input wire logic core_clk,
  // engine outputs
  output logic page_received,
  output logic [15:0] partner_page,
  output logic page_rx_var,
  output logic page_sent,
  output logic sent_toggle,
  output logic link_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {page_received, page_rx_var, page_sent, sent_toggle, link_ok} = 5'h00;
    partner_page = 16'h0000;
  end
  // word is inverted after the pulse so a stale hold cannot pass
  task automatic deliver(input logic [15:0] word);
    @(negedge core_clk);
    partner_page = word;
    page_received = 1'b1;
    page_rx_var = 1'b1;
    @(negedge core_clk);
    page_received = 1'b0;
    partner_page = ~word;
  endtask
  task automatic transmit(input logic t);
    @(negedge core_clk);
    sent_toggle = t;
    page_sent = 1'b1;
    @(negedge core_clk);
    page_sent = 1'b0;
    sent_toggle = ~t;
  endtask
  task automatic set_link(input logic l);
    @(negedge core_clk);
    link_ok = l;
  endtask
  task automatic drop_rx_var();
    @(negedge core_clk);
    page_rx_var = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench/phy_next_page_port_config_regs_tb.sv
// self-checking bench for the next-page and port configuration bank
`default_nettype none
module phy_next_page_port_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic fiber_strap = 1'b1;
  logic mgmt_write = 1'b0;
  logic mgmt_read = 1'b0;
  logic [4:0] mgmt_addr = 5'h00;
  logic [15:0] mgmt_wdata = 16'h0000;
  logic [15:0] mgmt_rdata, outgoing_page, partner_page;
  logic mgmt_rvalid, page_received, page_rx_var, page_sent, sent_toggle;
  logic link_ok, page_received_flag, link_pass, transmit_enable;
  logic scrambler_enable, block_code_enable, jabber_enable;
  logic heartbeat_test_enable, half_duplex_loopback_enable, carrier_extend;
  logic preamble_delivery, serial_receive_mode, far_end_fault_enable;
  logic alternate_next_page, fiber_mode;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #4 core_clk = ~core_clk;
  pnpc_an_partner pnpc_an_partner_inst (.core_clk, .page_received,
    .partner_page, .page_rx_var, .page_sent, .sent_toggle, .link_ok);
  pnpc_regs pnpc_regs_inst (.core_clk, .reset, .fiber_strap, .mgmt_write,
    .mgmt_read, .mgmt_addr, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid,
    .page_received, .partner_page, .page_rx_var, .page_sent, .sent_toggle,
    .link_ok, .outgoing_page, .page_received_flag, .link_pass,
    .transmit_enable, .scrambler_enable, .block_code_enable, .jabber_enable,
    .heartbeat_test_enable, .half_duplex_loopback_enable, .carrier_extend,
    .preamble_delivery, .serial_receive_mode, .far_end_fault_enable,
    .alternate_next_page, .fiber_mode);
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge core_clk);
    {mgmt_addr, mgmt_wdata, mgmt_write} = {a, d, 1'b1};
    @(negedge core_clk);
    mgmt_write = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(negedge core_clk);
    {mgmt_addr, mgmt_read} = {a, 1'b1};
    @(negedge core_clk);
    mgmt_read = 1'b0;
    cmp({15'h0000, mgmt_rvalid}, 16'h0001);
    cmp(mgmt_rdata, e);
  endtask
  // control outputs against a configuration word, link test failing
  task automatic ctl(input logic [15:0] c);
    repeat (2) @(negedge core_clk);
    cmp({3'h0, link_pass, transmit_enable, scrambler_enable,
      block_code_enable, jabber_enable, heartbeat_test_enable,
      half_duplex_loopback_enable, carrier_extend, preamble_delivery,
      serial_receive_mode, far_end_fault_enable, alternate_next_page,
      fiber_mode}, {3'h0, c[14], ~c[13:10], c[9], ~c[8], c[7], c[5],
      c[3:0]});
  endtask
  task automatic t_reset(input logic s);
    rd(5'h07, 16'h2001);
    rd(5'h08, 16'h0000);
    rd(5'h10, {15'h0042, s});
    ctl({15'h0042, s});
  endtask
  // reset in mid-run with the strap low brings back every reset value
  task automatic t_rerun();
    @(negedge core_clk);
    {reset, fiber_strap} = 2'b10;
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    cmp({15'h0000, page_received_flag}, 16'h0000);
    t_reset(1'b0);
  endtask
  task automatic t_config();
    logic [15:0] v [4] = '{16'hffff, 16'h0000, 16'h2aaa, 16'h5555};
    foreach (v[i]) begin
      wr(5'h10, v[i]);
      rd(5'h10, v[i] & pnpc_pkg::port_configuration_mask);
      ctl(v[i] & pnpc_pkg::port_configuration_mask);
    end
    wr(5'h10, 16'h0000);
    pnpc_an_partner_inst.set_link(1'b1);
    repeat (2) @(negedge core_clk);
    cmp({15'h0000, link_pass}, 16'h0001);
    pnpc_an_partner_inst.set_link(1'b0);
    repeat (2) @(negedge core_clk);
    cmp({15'h0000, link_pass}, 16'h0000);
  endtask
  task automatic t_outgoing();
    wr(5'h07, 16'hffff);
    rd(5'h07, 16'hb7ff);
    pnpc_an_partner_inst.transmit(1'b0);
    repeat (2) @(negedge core_clk);
    cmp(outgoing_page, 16'hbfff);
    pnpc_an_partner_inst.transmit(1'b1);
    rd(5'h07, 16'hb7ff);
  endtask
  task automatic t_partner();
    pnpc_an_partner_inst.deliver(16'hfedc);
    cmp({15'h0000, page_received_flag}, 16'h0001);
    wr(5'h08, 16'h0000);
    rd(5'h08, 16'hfedc);
    cmp({15'h0000, page_received_flag}, 16'h0000);
    wr(5'h1f, 16'hffff);
    rd(5'h1f, 16'h0000);
  endtask
  // alternate mode drops the flag when the variable falls; normal keeps it
  task automatic t_alternate(input logic alt);
    wr(5'h10, {14'h0000, alt, 1'b0});
    pnpc_an_partner_inst.deliver(16'h1234);
    pnpc_an_partner_inst.drop_rx_var();
    repeat (2) @(negedge core_clk);
    cmp({15'h0000, page_received_flag}, {15'h0000, ~alt});
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    repeat (3) @(negedge core_clk);
    t_reset(1'b1);
    t_config();
    t_outgoing();
    t_partner();
    t_alternate(1'b1);
    t_alternate(1'b0);
    t_rerun();
    conclude();
  end
endmodule
`default_nettype wire
